// ==== pmp_mac_model.sv ====
// MAC transmit model facing the pin block
`timescale 1ns/1ps
module pmp_mac_model (
    // Link side
    input wire logic link_clk,
    output logic ref_clk,
    output logic tx_en,
    output logic [3:0] tx_d,
    // Test control
    input wire logic send,
    input wire logic [3:0] nib
);
    // --------
    // Reference and transmit driver
    // --------
    initial begin
        ref_clk = 1'b0;
        forever #100 ref_clk = ~ref_clk;
    end
    // Idle data flips every rising link clock edge so a stale nibble cannot pass
    initial begin
        tx_en = 1'b0;
        tx_d = 4'h0;
        forever begin
            @(posedge link_clk);
            tx_en <= send;
            tx_d <= send ? nib : ~tx_d;
        end
    end
endmodule

// ==== pmp_mac_pins.sv ====
// MAC-facing pin logic of a 10/100 transceiver with an APB register slave
//
// Function
// R1: Hardware reset pin returns all internal registers to default values; the divider, blink phase and APB read data are not reset by it.
// R2: The outside party holds the hardware reset low for at least 10 ms; the bench holds it low for 6 pclk cycles.
// R3: MII transmit clock runs 25 MHz at 100 Mb/s, 2.5 MHz at 10 Mb/s; the divider gives 20 MHz at 100 Mb/s.
// R4: RMII uses one 50 MHz reference on the transmit clock pin, either direction; the driven reference is 20 MHz.
// R5: Receive data bit 3 strap picks clock direction: 0 output, 1 input.
// R6: Transmit enable is active high, sampled on the transmit clock rising edge.
// R7: Transmit enable qualifies four data bits in MII, two low bits in RMII.
// R8: The MAC drives transmit data with the transmit clock while enabled.
// R9: Media mode from receive-valid and bit 3 straps: MII, reverse MII, RMII out, in.
// R10: MII receive data valid is high exactly while receive data is valid.
// R11: Receive error flags error symbols inside packets, on the receive clock edge.
// R12: Received symbols appear on receive data on the receive clock rising edge.
// R13: Receive data bit 1 strap makes the first LED pin LED or wake output.
// R14: In RMII receive data bit 2 becomes the open-drain interrupt output.
// R15: MII collision low in full duplex; in half duplex only when both media busy.
// R16: First LED lights on 10 Mb/s link and blinks on activity.
// R17: PHY address bit 0 comes from the first LED pin strap.
// R18: Second LED shows 100 Mb/s link with blink; its strap gives address bit 1.
// R19: Strap pins are captured at reset and used as configuration afterwards.
// R20: RMII combined carrier-sense and data-valid follows the non-idle medium.
// R21: MII carrier sense follows the non-idle medium; receive clock matches transmit clock.
`timescale 1ns/1ps
`include "pmp_params.svh"
module pmp_mac_pins
    import pmp_pkg::*;
#(
    parameter int BLINK_CYCLES = `PMP_BLINK_CYC
)
(
    // Clock and bus reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Hardware reset pin
    input wire logic hw_reset_n,
    // MAC transmit pins
    input wire logic tx_clk_i,
    output logic tx_clk_o,
    output logic tx_clk_oe,
    input wire logic tx_en,
    input wire logic [3:0] tx_d,
    // MAC receive pins
    output logic rx_clk,
    input wire logic rx_dv_i,
    output logic rx_dv_o,
    output logic rx_dv_oe,
    input wire logic [3:0] rx_d_i,
    output logic [3:0] rx_d_o,
    output logic [3:0] rx_d_oe,
    output logic rx_er,
    output logic crs,
    output logic col,
    // LED pins
    input wire logic link10_led_i,
    output logic link10_led_o,
    output logic link10_led_oe,
    input wire logic link100_led_i,
    output logic link100_led_o,
    output logic link100_led_oe,
    // Line side, receive
    input wire logic line_rx_active,
    input wire logic line_rx_valid,
    input wire logic [3:0] line_rx_data,
    input wire logic line_rx_err,
    // Line side, transmit
    output logic line_tx_valid,
    output logic [3:0] line_tx_data
);
    localparam logic [3:0] HALF_100 = 4'(`PMP_NS2CYC(`PMP_HALF_100_NS));
    localparam logic [3:0] HALF_10 = 4'(`PMP_NS2CYC(`PMP_HALF_10_NS));
    localparam logic [3:0] HALF_RMII = 4'(`PMP_NS2CYC(`PMP_HALF_RMII_NS));
    localparam logic [20:0] BLINK_LAST = 21'(BLINK_CYCLES - 1);

    typedef struct packed {
        logic tx_en_m;
        logic tx_en_s;
        logic [3:0] txd_m;
        logic [3:0] txd_s;
        logic tx_en_d;
        logic [3:0] txd_d;
        logic rst_m;
        logic rst_s;
        logic ck_m;
        logic ck_s;
        logic ck_d;
        logic [3:0] div_cnt;
        logic ck_q;
        logic [4:0] ctrl;
        logic [15:0] tx_cnt;
        logic [15:0] rx_cnt;
        logic [3:0] rxd;
        logic rx_dv;
        logic rx_er;
        logic crs;
        logic col;
        logic ltx_valid;
        logic [3:0] ltx_data;
        logic tx_active;
        logic [20:0] blink_cnt;
        logic blink;
        logic [31:0] prdata;
        logic pslverr;
    } pmp_state_t;

    pmp_state_t q;
    pmp_state_t next_q;
    pmp_strap_if sif ();

    logic core_rst;
    logic rmii;
    logic ck_in_sel;
    logic tick;
    logic [3:0] half;
    logic act;
    logic led10_on;
    logic led100_on;
    logic [31:0] stat_word;
    logic smp_en;
    logic [3:0] smp_d;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == `PMP_OFF_CTRL) || (a == `PMP_OFF_STAT) ||
                   (a == `PMP_OFF_TXCNT) || (a == `PMP_OFF_RXCNT);
    endfunction

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    assign sif.pin_dv = rx_dv_i;
    assign sif.pin_d3 = rx_d_i[3];
    assign sif.pin_d1 = rx_d_i[1];
    assign sif.pin_link10_led = link10_led_i;
    assign sif.pin_link100_led = link100_led_i;
    assign sif.rearm = core_rst;

    pmp_strap u_strap (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    assign core_rst = ~q.rst_s;
    assign rmii = (sif.mode == PMP_RMII_CKOUT) || (sif.mode == PMP_RMII_CKIN);
    assign ck_in_sel = rmii && sif.clk_in; // R4 R5

    // Supplied reference is seen late, so stage two already holds what its edge launched
    assign smp_en = ck_in_sel ? q.tx_en_d : q.tx_en_s; // R6
    assign smp_d = ck_in_sel ? q.txd_d : q.txd_s; // R6

    always_comb begin
        if (rmii) begin
            half = HALF_RMII; // R4
        end else if (q.ctrl[`PMP_CTRL_SPD100]) begin
            half = HALF_100; // R3
        end else begin
            half = HALF_10; // R3
        end
    end

    assign stat_word = {22'h0, q.col, q.crs, q.tx_active, sif.done, sif.addr,
                        sif.wol_sel, sif.clk_in, sif.mode};

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_q = q;
        tick = 1'b0;
        next_q.tx_en_m = tx_en;
        next_q.tx_en_s = q.tx_en_m;
        next_q.txd_m = tx_d;
        next_q.txd_s = q.txd_m;
        next_q.tx_en_d = q.tx_en_s;
        next_q.txd_d = q.txd_s;
        next_q.rst_m = hw_reset_n;
        next_q.rst_s = q.rst_m;
        next_q.ck_m = tx_clk_i;
        next_q.ck_s = q.ck_m;
        next_q.ck_d = q.ck_s;
        next_q.ltx_valid = 1'b0;

        // Link clock: own divider, or edges of the supplied reference
        if (ck_in_sel) begin
            tick = q.ck_s & ~q.ck_d; // R4
            next_q.ck_q = 1'b0;
            next_q.div_cnt = 4'h0;
        end else if (q.div_cnt == 4'h0) begin
            next_q.div_cnt = half - 4'h1; // R3
            next_q.ck_q = ~q.ck_q;
            tick = ~q.ck_q;
        end else begin
            next_q.div_cnt = q.div_cnt - 4'h1;
        end

        if (tick && sif.done) begin
            next_q.tx_active = smp_en; // R6
            next_q.ltx_valid = smp_en; // R6
            if (rmii) begin
                next_q.ltx_data = {2'b00, smp_d[1:0]}; // R7
            end else begin
                next_q.ltx_data = smp_d; // R7
            end
            if (smp_en) begin
                next_q.tx_cnt = q.tx_cnt + 16'h1;
            end
            next_q.rxd = line_rx_data; // R12
            next_q.rx_dv = line_rx_valid; // R10
            next_q.rx_er = line_rx_err & line_rx_valid; // R11
            if (rmii) begin
                next_q.crs = line_rx_active; // R20
                next_q.col = 1'b0;
            end else begin
                next_q.crs = line_rx_active | smp_en; // R21
                next_q.col = ~q.ctrl[`PMP_CTRL_FDX] & smp_en & line_rx_active; // R15
            end
            if (line_rx_valid) begin
                next_q.rx_cnt = q.rx_cnt + 16'h1;
            end
        end

        // Activity blink phase
        if (q.blink_cnt == BLINK_LAST) begin
            next_q.blink_cnt = 21'h0;
            next_q.blink = ~q.blink;
        end else begin
            next_q.blink_cnt = q.blink_cnt + 21'h1;
        end

        // APB: read data captured in setup, write taken in access
        next_q.pslverr = 1'b0;
        if (psel && !penable) begin
            case (paddr)
                `PMP_OFF_CTRL: next_q.prdata = {27'h0, q.ctrl};
                `PMP_OFF_STAT: next_q.prdata = stat_word;
                `PMP_OFF_TXCNT: next_q.prdata = {16'h0, q.tx_cnt};
                `PMP_OFF_RXCNT: next_q.prdata = {16'h0, q.rx_cnt};
                default: next_q.prdata = 32'h0;
            endcase
            next_q.pslverr = ~addr_hit(paddr);
        end else if (psel && penable) begin
            next_q.pslverr = q.pslverr;
            if (pwrite && paddr == `PMP_OFF_CTRL) begin
                next_q.ctrl = pwdata[4:0];
            end
        end

        // Hardware reset pin restores defaults
        if (core_rst) begin
            next_q.ctrl = `PMP_CTRL_RESET; // R1
            next_q.tx_cnt = 16'h0; // R1
            next_q.rx_cnt = 16'h0; // R1
            next_q.rxd = 4'h0;
            next_q.rx_dv = 1'b0;
            next_q.rx_er = 1'b0;
            next_q.crs = 1'b0;
            next_q.col = 1'b0;
            next_q.tx_active = 1'b0;
            next_q.ltx_valid = 1'b0;
            next_q.ltx_data = 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // ----------------------------------------------------------------
    // APB outputs
    // ----------------------------------------------------------------
    assign pready = 1'b1;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr & psel & penable;

    // ----------------------------------------------------------------
    // Pins
    // ----------------------------------------------------------------
    assign tx_clk_o = q.ck_q;
    assign tx_clk_oe = sif.done & ~ck_in_sel; // R4 R5
    assign rx_clk = q.ck_q & ~rmii; // R21
    assign rx_dv_o = q.rx_dv; // R10
    assign rx_dv_oe = sif.done & ~rmii;
    assign rx_er = q.rx_er;
    assign crs = q.crs;
    assign col = q.col;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_rxd_low
            assign rx_d_o[gi] = q.rxd[gi]; // R12
            assign rx_d_oe[gi] = sif.done;
        end
    endgenerate

    // Bit 2 is the open-drain interrupt in RMII, data in MII
    assign rx_d_o[2] = rmii ? 1'b0 : q.rxd[2]; // R14
    assign rx_d_oe[2] = sif.done & (rmii ? q.ctrl[`PMP_CTRL_IRQ] : 1'b1); // R14
    assign rx_d_o[3] = q.rxd[3];
    assign rx_d_oe[3] = sif.done & ~rmii;

    assign act = q.tx_active | q.crs;
    assign led10_on = q.ctrl[`PMP_CTRL_LINK] & ~q.ctrl[`PMP_CTRL_SPD100] & ~(act & q.blink); // R16
    assign led100_on = q.ctrl[`PMP_CTRL_LINK] & q.ctrl[`PMP_CTRL_SPD100] & ~(act & q.blink); // R18

    // First LED pin doubles as the open-drain wake output
    assign link10_led_o = sif.wol_sel ? 1'b0 : led10_on; // R13
    assign link10_led_oe = sif.done & (sif.wol_sel ? q.ctrl[`PMP_CTRL_WOL] : 1'b1); // R13
    assign link100_led_o = led100_on;
    assign link100_led_oe = sif.done;

    assign line_tx_valid = q.ltx_valid;
    assign line_tx_data = q.ltx_data;
endmodule

// ==== pmp_mac_pins_bench.sv ====
// Self-checking bench of the MAC-side pin block
`timescale 1ns/1ps
`include "pmp_params.svh"
module pmp_mac_pins_bench
    import pmp_pkg::*;
;
    // --------
    // Signals
    // --------
    localparam int W = 160;
    localparam int E100 = W / (2 * `PMP_NS2CYC(`PMP_HALF_100_NS));
    localparam int E10 = W / (2 * `PMP_NS2CYC(`PMP_HALF_10_NS));
    localparam int ERM = W / 8;
    localparam logic [11:0] CTRL = `PMP_OFF_CTRL;
    localparam logic [11:0] STAT = `PMP_OFF_STAT;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, n_tv = 32'h0, n_ck = 32'h0, a, b, z;
    logic pready, pslverr, er, hw_reset_n = 1'b1, send = 1'b0, ref_on = 1'b0, ref_clk, tx_en;
    logic s_dv = 1'b0, s_d3 = 1'b0, s_d1 = 1'b0, s_l0 = 1'b0, s_l1 = 1'b0, ck_q = 1'b0;
    logic lr_act = 1'b0, lr_val = 1'b0, lr_err = 1'b0, line_tx_valid;
    logic [3:0] lr_dat = 4'h0, nib = 4'h0, tx_d, rx_d_o, rx_d_oe, rx_d_i, line_tx_data, last_td = 4'h0;
    logic tx_clk_o, tx_clk_oe, tx_pin, rx_clk, rx_dv_o, rx_dv_oe, rx_dv_i, rx_er, crs, col;
    logic l10_o, l10_oe, l10_i, l100_o, l100_oe, l100_i;
    int n_errors = 0, total_checks = 0, cyc = 0;

    always #12.5 pclk = ~pclk;
    // Pin levels from all drivers; released straps fall to their pulls
    assign tx_pin = tx_clk_oe ? tx_clk_o : ref_on & ref_clk;
    assign rx_dv_i = rx_dv_oe ? rx_dv_o : s_dv;
    assign rx_d_i[0] = rx_d_oe[0] ? rx_d_o[0] : 1'b0;
    assign rx_d_i[1] = rx_d_oe[1] ? rx_d_o[1] : s_d1;
    assign rx_d_i[2] = rx_d_oe[2] ? rx_d_o[2] : 1'b1;
    assign rx_d_i[3] = rx_d_oe[3] ? rx_d_o[3] : s_d3;
    assign l10_i = l10_oe ? l10_o : s_l0;
    assign l100_i = l100_oe ? l100_o : s_l1;

    pmp_mac_pins #(.BLINK_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hw_reset_n(hw_reset_n), .tx_clk_i(tx_pin), .tx_clk_o(tx_clk_o), .tx_clk_oe(tx_clk_oe), .tx_en(tx_en),
        .tx_d(tx_d), .rx_clk(rx_clk), .rx_dv_i(rx_dv_i), .rx_dv_o(rx_dv_o), .rx_dv_oe(rx_dv_oe),
        .rx_d_i(rx_d_i), .rx_d_o(rx_d_o), .rx_d_oe(rx_d_oe), .rx_er(rx_er), .crs(crs), .col(col),
        .link10_led_i(l10_i), .link10_led_o(l10_o), .link10_led_oe(l10_oe), .link100_led_i(l100_i),
        .link100_led_o(l100_o), .link100_led_oe(l100_oe), .line_rx_active(lr_act), .line_rx_valid(lr_val),
        .line_rx_data(lr_dat), .line_rx_err(lr_err), .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data));
    pmp_mac_model mac (.link_clk(tx_pin), .ref_clk(ref_clk), .tx_en(tx_en), .tx_d(tx_d), .send(send), .nib(nib));

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        ck_q <= tx_clk_o;
        n_ck <= n_ck + 32'(tx_clk_o & ~ck_q);
        if (line_tx_valid) begin
            n_tv <= n_tv + 32'h1;
            last_td <= line_tx_data;
        end
        if (cyc == 40000) begin
            n_errors = n_errors + 1;
            finish_test();
        end
    end

    // --------
    // Shared tasks
    // --------
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] lo, hi, got);
        total_checks++;
        if ((^got === 1'bx) || got < lo || got > hi) begin
            n_errors++;
            $display("MISMATCH %s expected %0h..%0h seen %0h", nm, lo, hi, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic ctrl(input logic [31:0] d);
        apb(1'b1, CTRL, d);
        tick(2);
    endtask
    task automatic strap(input logic [1:0] m, input logic d1, l0, l1);
        logic [6:0] e;
        e = {1'b1, l1, l0, d1, m[0], m};
        hw_reset_n <= 1'b0;
        {s_dv, s_d3, s_d1, s_l0, s_l1} <= {m, d1, l0, l1};
        tick(6);
        hw_reset_n <= 1'b1;
        do apb(1'b0, STAT, 32'h0); while (rd[6] !== 1'b1);
        {s_dv, s_d3, s_d1, s_l0, s_l1} <= 5'h00;
        chk("strap", 32'(e), 32'(e), rd);
        apb(1'b0, CTRL, 32'h0);
        chk("ctrl_clear", 0, 0, rd);
        apb(1'b0, STAT, 32'h0);
        chk("strap_kept", 32'(e), 32'(e), rd);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // --------
    // Scenarios
    // --------
    task automatic t_regs;
        apb(1'b0, CTRL, 32'h0);
        chk("ctrl_reset", 0, 0, rd);
        apb(1'b1, CTRL, 32'hffffffff);
        apb(1'b0, CTRL, 32'h0);
        chk("ctrl_rw", 32'h1f, 32'h1f, rd);
        apb(1'b1, 12'h010, 32'h1);
        chk("bad_err", 1, 1, 32'(er));
        apb(1'b0, 12'h010, 32'h0);
        chk("bad_rd", 0, 0, rd);
    endtask
    task automatic t_mii;
        ctrl(32'h3);
        nib <= 4'ha;
        send <= 1'b1;
        tick(8);
        a = n_ck;
        b = n_tv;
        tick(W);
        chk("ck100", E100 - 1, E100 + 1, n_ck - a);
        chk("tv100", E100 - 1, E100 + 1, n_tv - b);
        chk("txd", 4'ha, 4'ha, 32'(last_td));
        lr_act <= 1'b1;
        tick(20);
        chk("col_hdx", 2'b11, 2'b11, {col, crs});
        apb(1'b0, STAT, 32'h0);
        chk("stat_busy", 3'h7, 3'h7, rd[9:7]);
        ctrl(32'h7);
        tick(20);
        chk("col_fdx", 0, 0, col);
        {lr_val, lr_dat, lr_err} <= 6'h2b;
        tick(20);
        chk("rx", 6'h2b, 6'h2b, {rx_dv_o, rx_d_o, rx_er});
        {lr_val, lr_err} <= 2'b00;
        tick(20);
        chk("rx_end", 0, 0, {rx_dv_o, rx_er});
        apb(1'b0, 12'h00c, 32'h0);
        chk("rx_cnt", 9, 11, rd);
        ctrl(32'h5);
        a = n_ck;
        tick(W);
        chk("ck10", E10 - 1, E10 + 1, n_ck - a);
        apb(1'b0, 12'h008, 32'h0);
        chk("tx_cnt", n_tv - 1, n_tv + 1, rd);
        send <= 1'b0;
        lr_act <= 1'b0;
    endtask
    task automatic t_led;
        // Activity from the last transfer needs two 10 Mb/s link ticks to clear
        tick(48);
        chk("led10_on", 2'b01, 2'b01, {l100_o, l10_o});
        lr_act <= 1'b1;
        z = 0;
        repeat (64) begin
            @(posedge pclk);
            z = z + 32'(!l10_o);
        end
        chk("led10_blink", 8, 56, z);
        lr_act <= 1'b0;
        ctrl(32'h3);
        tick(20);
        chk("led100_on", 2'b10, 2'b10, {l100_o, l10_o});
    endtask
    task automatic t_rmii;
        strap(PMP_RMII_CKOUT, 1'b0, 1'b0, 1'b0);
        a = n_ck;
        tick(W);
        chk("ref_out", E100 - 1, E100 + 1, n_ck - a);
        chk("ref_dir_out", 1, 1, tx_clk_oe);
        strap(PMP_RMII_CKIN, 1'b1, 1'b0, 1'b0);
        ref_on <= 1'b1;
        ctrl(32'h19);
        chk("ref_dir_in", 0, 0, tx_clk_oe);
        chk("irq_on", 2'b10, 2'b10, {rx_d_oe[2], rx_d_o[2]});
        chk("wol_on", 2'b10, 2'b10, {l10_oe, l10_o});
        nib <= 4'hf;
        send <= 1'b1;
        lr_act <= 1'b1;
        tick(16);
        b = n_tv;
        tick(W);
        chk("tv_rmii", ERM - 1, ERM + 1, n_tv - b);
        chk("txd_rmii", 4'h3, 4'h3, 32'(last_td));
        chk("crs_dv", 2'b10, 2'b10, {crs, col});
        send <= 1'b0;
        lr_act <= 1'b0;
        ctrl(32'h0);
        chk("irq_off", 0, 0, {rx_d_oe[2], l10_oe});
    endtask

    initial begin
        tick(20);
        presetn <= 1'b1;
        t_regs();
        strap(PMP_REV_MII, 1'b1, 1'b0, 1'b1);
        strap(PMP_MII, 1'b0, 1'b1, 1'b0);
        t_mii();
        t_led();
        t_rmii();
        finish_test();
    end
endmodule

// ==== pmp_mac_pins_chk.sv ====
// Concurrent checks on the pins of the MAC-side block
`timescale 1ns/1ps
module pmp_mac_pins_chk #(
    parameter int BLINK_CYCLES = 8
)
(
    // Clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hw_reset_n,
    // Clock pins
    input wire logic tx_clk_o,
    input wire logic tx_clk_oe,
    input wire logic rx_clk,
    // Receive pins
    input wire logic rx_dv_o,
    input wire logic rx_dv_oe,
    input wire logic [3:0] rx_d_o,
    input wire logic [3:0] rx_d_oe,
    input wire logic rx_er,
    input wire logic crs,
    input wire logic col,
    // Line transmit
    input wire logic line_tx_valid,
    input wire logic [3:0] line_tx_data
);
    // --------
    // Properties
    // --------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Low pair driven but bit 3 released: an RMII mode after capture
    wire rmii = rx_d_oe[0] && !rx_d_oe[3];

    chk_rst_clears: assert property (!hw_reset_n [*5] |-> !rx_er && !crs && !col)
        else $error("receive outputs not cleared in reset");
    chk_col_carrier: assert property (col |-> crs)
        else $error("collision without carrier");
    chk_er_valid: assert property (rx_er |-> rx_dv_o)
        else $error("receive error outside valid data");
    chk_rmii_dibit: assert property (line_tx_valid && rmii |-> line_tx_data[3:2] == 2'h0)
        else $error("upper transmit bits used in RMII");
    chk_irq_od: assert property (rmii |-> !rx_d_o[2] && !col)
        else $error("interrupt pin driven high or collision in RMII");
    chk_no_drive: assert property (!rx_d_oe[0] |-> !tx_clk_oe && !rx_dv_oe)
        else $error("pins driven before capture");
    chk_ref_half: assert property (rmii && tx_clk_oe && $rose(tx_clk_o) |=> !tx_clk_o)
        else $error("reference output half period wrong");
    chk_rx_clk_copy: assert property (rx_d_oe[3] && tx_clk_oe |-> rx_clk == tx_clk_o)
        else $error("receive clock differs from transmit clock");
    chk_tx_pulse: assert property (line_tx_valid |=> !line_tx_valid)
        else $error("more than one sample per link edge");

    cover property (col);
    cover property (rx_er);
    cover property (rmii && line_tx_valid);
endmodule

bind pmp_mac_pins pmp_mac_pins_chk #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .hw_reset_n(hw_reset_n), .tx_clk_o(tx_clk_o), .tx_clk_oe(tx_clk_oe),
    .rx_clk(rx_clk), .rx_dv_o(rx_dv_o), .rx_dv_oe(rx_dv_oe), .rx_d_o(rx_d_o), .rx_d_oe(rx_d_oe),
    .rx_er(rx_er), .crs(crs), .col(col), .line_tx_valid(line_tx_valid), .line_tx_data(line_tx_data));

// ==== pmp_params.svh ====
// Constants for the MAC-side pin block: offsets, bit positions, reset values, timing
`ifndef PMP_PARAMS_SVH
`define PMP_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define PMP_PCLK_PS 25000
`define PMP_NS2CYC(ns) ((((ns) * 1000) + `PMP_PCLK_PS - 1) / `PMP_PCLK_PS)
`define PMP_HALF_100_NS 20
`define PMP_HALF_10_NS 200
`define PMP_HALF_RMII_NS 10
`define PMP_HW_RESET_MIN_MS 10
`define PMP_BLINK_MS 40
`define PMP_BLINK_CYC ((`PMP_BLINK_MS * 1000000) / (`PMP_PCLK_PS / 1000))
`define PMP_STRAP_SETTLE 3'h4

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PMP_OFF_CTRL 12'h000
`define PMP_OFF_STAT 12'h004
`define PMP_OFF_TXCNT 12'h008
`define PMP_OFF_RXCNT 12'h00c

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define PMP_CTRL_LINK 0
`define PMP_CTRL_SPD100 1
`define PMP_CTRL_FDX 2
`define PMP_CTRL_IRQ 3
`define PMP_CTRL_WOL 4
`define PMP_CTRL_RESET 5'h00
`define PMP_STAT_MODE 0
`define PMP_STAT_CLKIN 2
`define PMP_STAT_WOLSEL 3
`define PMP_STAT_ADDR 4
`define PMP_STAT_DONE 6
`define PMP_STAT_TXACT 7
`define PMP_STAT_CRS 8
`define PMP_STAT_COL 9

`endif

// ==== pmp_pkg.sv ====
// Types shared by the MAC-side pin block
package pmp_pkg;
    typedef enum logic [1:0] {
        PMP_MII = 2'b00,
        PMP_REV_MII = 2'b01,
        PMP_RMII_CKOUT = 2'b10,
        PMP_RMII_CKIN = 2'b11
    } pmp_media_t;

    typedef enum logic [1:0] {
        PMP_ST_WAIT = 2'b00,
        PMP_ST_CAPT = 2'b01,
        PMP_ST_DONE = 2'b10
    } pmp_strap_st_t;
endpackage

// ==== pmp_strap.sv ====
// Strap capture unit: samples bootstrap pin levels after each reset release
`timescale 1ns/1ps
`include "pmp_params.svh"
module pmp_strap
    import pmp_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Core side
    pmp_strap_if.strap sif
);
    typedef struct packed {
        logic [4:0] m;
        logic [4:0] s;
        logic [2:0] cnt;
        pmp_strap_st_t st;
        logic [4:0] cap;
    } pmp_strap_state_t;

    pmp_strap_state_t q;
    pmp_strap_state_t next_q;

    always_comb begin
        next_q = q;
        next_q.m = {sif.pin_link100_led, sif.pin_link10_led, sif.pin_d1, sif.pin_d3, sif.pin_dv};
        next_q.s = q.m;
        case (q.st)
            PMP_ST_WAIT: begin
                next_q.cnt = q.cnt + 3'h1;
                if (q.cnt == `PMP_STRAP_SETTLE) begin
                    next_q.st = PMP_ST_CAPT;
                end
            end
            PMP_ST_CAPT: begin
                next_q.cap = q.s; // R19
                next_q.st = PMP_ST_DONE;
            end
            PMP_ST_DONE: begin
                next_q.st = PMP_ST_DONE;
            end
            default: begin
                next_q.st = PMP_ST_WAIT;
            end
        endcase
        if (sif.rearm) begin
            next_q.st = PMP_ST_WAIT; // R19
            next_q.cnt = 3'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign sif.done = (q.st == PMP_ST_DONE);
    assign sif.mode = pmp_media_t'({q.cap[0], q.cap[1]}); // R9
    assign sif.clk_in = q.cap[1]; // R5
    assign sif.wol_sel = q.cap[2]; // R13
    assign sif.addr = {q.cap[4], q.cap[3]}; // R17 R18
endmodule

// ==== pmp_strap_if.sv ====
// Interface between the pin core and the strap capture unit
`timescale 1ns/1ps
interface pmp_strap_if;
    import pmp_pkg::*;
    logic pin_dv;
    logic pin_d3;
    logic pin_d1;
    logic pin_link10_led;
    logic pin_link100_led;
    logic rearm;
    logic done;
    pmp_media_t mode;
    logic clk_in;
    logic wol_sel;
    logic [1:0] addr;

    modport core (output pin_dv, pin_d3, pin_d1, pin_link10_led, pin_link100_led, rearm,
                  input done, mode, clk_in, wol_sel, addr);
    modport strap (input pin_dv, pin_d3, pin_d1, pin_link10_led, pin_link100_led, rearm,
                   output done, mode, clk_in, wol_sel, addr);
endinterface
